//--- rtl/umlc_modem_line_control.sv
module umlc_modem_line_control
(
  // Clock, reset, enable
  input  wire logic                        clk_in,
  input  wire logic                        rstn_in,
  input  wire logic                        ce_in,
  // Register write and read
  input  wire logic                        wr_en_in,
  input  wire logic [umlc_pkg::UMLC_W-1:0] wr_data_in,
  input  wire logic [umlc_pkg::UMLC_W-1:0] efc_in,
  input  wire logic [umlc_pkg::UMLC_W-1:0] pin_func_in,
  input  wire logic [umlc_pkg::UMLC_W-1:0] pin_state_in,
  output logic      [umlc_pkg::UMLC_W-1:0] rd_data_out,
  // Datapath context
  input  wire logic                        auto_rts_en_in,
  input  wire logic                        auto_rts_n_in,
  input  wire logic                        tx_serial_in,
  input  wire logic                        rx_pin_in,
  input  wire logic                        cts_n_in,
  input  wire logic                        dsr_n_in,
  // Controls to the channel
  output logic                             baud_clk_en_out,
  output logic                             infrared_out,
  output logic                             any_resume_out,
  output logic                             loopback_out,
  output logic                             trig_regs_en_out,
  output logic                             rx_serial_out,
  output logic                             status_cts_out,
  output logic                             status_dsr_out,
  // Modem pins
  output logic                             send_req_n_out,
  output logic                             pin_five_out,
  output logic                             pin_one_out
);
  import umlc_pkg::*;

  // Control word held by the register
  logic [UMLC_W-1:0] ctl_r;
  logic [UMLC_W-1:0] ctl_nxt;
  // Prescaler phase and baud enable
  logic [1:0]        div_r;
  logic [1:0]        div_nxt;
  logic              bce_r;
  logic              bce_nxt;
  // Channel mode flags
  logic              infra_r;
  logic              infra_nxt;
  logic              resume_r;
  logic              resume_nxt;
  logic              trig_r;
  logic              trig_nxt;
  // Receive path and modem status
  logic              rx_r;
  logic              rx_nxt;
  logic              cts_r;
  logic              cts_nxt;
  logic              dsr_r;
  logic              dsr_nxt;
  // Modem pins
  logic              send_n_r;
  logic              send_n_nxt;
  logic              five_r;
  logic              five_nxt;
  logic              one_r;
  logic              one_nxt;
  // Decoded conditions
  logic              pin_sel;
  logic              gate_open;
  logic              loop_on;

  // Terminal-ready role, write gate and loopback decode
  assign pin_sel   = pin_func_in[UMLC_PIN_TR_BIT]
                   | pin_func_in[UMLC_PIN_TR_ALT];
  assign gate_open = efc_in[UMLC_EFC_WEN];
  assign loop_on   = ctl_r[UMLC_LOOPBACK];

  // Next control word: free bits always, gated bits behind enable
  always_comb
  begin
    ctl_nxt = ctl_r;
    if (wr_en_in)
    begin
      ctl_nxt = (ctl_r & ~UMLC_FREE_MASK)
              | (wr_data_in & UMLC_FREE_MASK);
      if (gate_open)
        ctl_nxt = (ctl_nxt & ~UMLC_GATED_MASK)
                | (wr_data_in & UMLC_GATED_MASK);
    end
    // Reserved bit never holds a one
    ctl_nxt[UMLC_RSVD] = 1'b0;
  end

  // Control word register; a low enable freezes it
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ctl_r <= UMLC_RESET;
    else if (ce_in)
      ctl_r <= ctl_nxt;
  end

  // Prescaler: a free-running phase picks one cycle in four
  always_comb
  begin
    div_nxt = div_r + 2'h1;
    bce_nxt = 1'b1;
    if (ctl_r[UMLC_PRESCALE])
      bce_nxt = (div_r == UMLC_DIV_LAST);
  end

  // Prescaler registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_r <= UMLC_DIV_RESET;
      bce_r <= UMLC_FLAG_RESET;
    end
    else if (ce_in)
    begin
      div_r <= div_nxt;
      bce_r <= bce_nxt;
    end
  end

  // Mode flags copied from the control word
  always_comb
  begin
    infra_nxt  = ctl_r[UMLC_INFRARED];
    resume_nxt = ctl_r[UMLC_ANY_RESUME];
    trig_nxt   = ctl_r[UMLC_TRIG_EN];
  end

  // Mode flag registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      infra_r  <= UMLC_FLAG_RESET;
      resume_r <= UMLC_FLAG_RESET;
      trig_r   <= UMLC_FLAG_RESET;
    end
    else if (ce_in)
    begin
      infra_r  <= infra_nxt;
      resume_r <= resume_nxt;
      trig_r   <= trig_nxt;
    end
  end

  // Receive source and modem status; loopback swaps in own signals
  always_comb
  begin
    rx_nxt  = rx_pin_in;
    cts_nxt = ~cts_n_in;
    dsr_nxt = ~dsr_n_in;
    if (loop_on)
    begin
      rx_nxt  = tx_serial_in;
      cts_nxt = ctl_r[UMLC_SEND_REQ];
      dsr_nxt = ctl_r[UMLC_TERM_RDY];
    end
  end

  // Receive and status registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rx_r  <= UMLC_FLAG_RESET;
      cts_r <= UMLC_FLAG_RESET;
      dsr_r <= UMLC_FLAG_RESET;
    end
    else if (ce_in)
    begin
      rx_r  <= rx_nxt;
      cts_r <= cts_nxt;
      dsr_r <= dsr_nxt;
    end
  end

  // Modem pins: auto flow owns send-request, control bit owns the
  // terminal-ready pins while they carry that role
  always_comb
  begin
    send_n_nxt = ~ctl_r[UMLC_SEND_REQ];
    if (auto_rts_en_in)
      send_n_nxt = auto_rts_n_in;
    five_nxt = pin_state_in[UMLC_PIN_FIVE];
    one_nxt  = pin_state_in[UMLC_PIN_ONE];
    if (pin_sel)
    begin
      // Pin state writes have no effect here
      five_nxt = ~ctl_r[UMLC_TERM_RDY];
      one_nxt  = ~ctl_r[UMLC_TERM_RDY];
    end
  end

  // Pin registers; pins idle high, that is inactive
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      send_n_r <= UMLC_PIN_IDLE;
      five_r   <= UMLC_PIN_IDLE;
      one_r    <= UMLC_PIN_IDLE;
    end
    else if (ce_in)
    begin
      send_n_r <= send_n_nxt;
      five_r   <= five_nxt;
      one_r    <= one_nxt;
    end
  end

  // Outputs come straight from the registers
  assign rd_data_out      = ctl_r;
  assign loopback_out     = ctl_r[UMLC_LOOPBACK];
  assign baud_clk_en_out  = bce_r;
  assign infrared_out     = infra_r;
  assign any_resume_out   = resume_r;
  assign trig_regs_en_out = trig_r;
  assign rx_serial_out    = rx_r;
  assign status_cts_out   = cts_r;
  assign status_dsr_out   = dsr_r;
  assign send_req_n_out   = send_n_r;
  assign pin_five_out     = five_r;
  assign pin_one_out      = one_r;

  // Prescaler steps as named sequences
  sequence div_last_s;
    ce_in && ctl_r[UMLC_PRESCALE] && (div_r == UMLC_DIV_LAST);
  endsequence
  sequence div_mid_s;
    ce_in && ctl_r[UMLC_PRESCALE] && (div_r != UMLC_DIV_LAST);
  endsequence

  // Write gating of the control word
  ctl_gate_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_en_in && !gate_open |=>
    (ctl_r & UMLC_GATED_MASK) == ($past(ctl_r) & UMLC_GATED_MASK))
    else $error("gated bits changed");
  gate_write_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_en_in && gate_open |=>
    (ctl_r & UMLC_GATED_MASK) == ($past(wr_data_in) & UMLC_GATED_MASK))
    else $error("gated write lost");
  free_bits_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_en_in |=>
    (ctl_r & UMLC_FREE_MASK) == ($past(wr_data_in) & UMLC_FREE_MASK))
    else $error("free bits write lost");
  rsv_zero_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ctl_r[UMLC_RSVD] == 1'b0)
    else $error("reserved bit set");
  free_write_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_en_in |=>
    ctl_r[UMLC_LOOPBACK] == $past(wr_data_in[UMLC_LOOPBACK]))
    else $error("loopback write lost");
  ce_freeze_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    !ce_in |=> $stable(ctl_r) && $stable(send_req_n_out))
    else $error("state moved while frozen");

  // Prescaler enable pattern
  div_fire_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    div_last_s |=> bce_r)
    else $error("prescaled enable missing");
  div_hold_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    div_mid_s |=> !bce_r)
    else $error("prescaled enable early");
  div_bypass_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && !ctl_r[UMLC_PRESCALE] |=> bce_r)
    else $error("undivided enable missing");

  // Mode flags follow the control word
  infra_flag_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> infrared_out == $past(ctl_r[UMLC_INFRARED]))
    else $error("infrared wrong");
  resume_flag_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> any_resume_out == $past(ctl_r[UMLC_ANY_RESUME]))
    else $error("resume option wrong");
  trig_flag_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> trig_regs_en_out == $past(ctl_r[UMLC_TRIG_EN]))
    else $error("trigger enable wrong");

  // Loopback routing of data and status
  loop_rx_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && loop_on |=> rx_serial_out == $past(tx_serial_in))
    else $error("loop data wrong");
  loop_cts_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && loop_on |=> status_cts_out == $past(ctl_r[UMLC_SEND_REQ]))
    else $error("loop status wrong");
  loop_dsr_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && loop_on |=> status_dsr_out == $past(ctl_r[UMLC_TERM_RDY]))
    else $error("loop ready status wrong");

  // Modem pin drive
  send_req_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && !auto_rts_en_in |=>
    send_req_n_out == !$past(ctl_r[UMLC_SEND_REQ]))
    else $error("send request wrong");
  auto_send_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && auto_rts_en_in |=> send_req_n_out == $past(auto_rts_n_in))
    else $error("auto send request wrong");
  pin_five_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && pin_sel |=> pin_five_out == !$past(ctl_r[UMLC_TERM_RDY]))
    else $error("terminal ready wrong");
  pin_one_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && pin_sel |=> pin_one_out == !$past(ctl_r[UMLC_TERM_RDY]))
    else $error("second terminal ready wrong");
endmodule : umlc_modem_line_control

//--- rtl/umlc_pkg.sv
package umlc_pkg;
  localparam int          UMLC_W         = 8;
  localparam logic [7:0]  UMLC_RESET     = 8'h00;
  localparam int          UMLC_PRESCALE  = 7;
  localparam int          UMLC_INFRARED  = 6;
  localparam int          UMLC_ANY_RESUME = 5;
  localparam int          UMLC_LOOPBACK  = 4;
  localparam int          UMLC_TRIG_EN   = 2;
  localparam int          UMLC_SEND_REQ  = 1;
  localparam int          UMLC_TERM_RDY  = 0;
  localparam logic [7:0]  UMLC_GATED_MASK = 8'hE4;
  localparam logic [7:0]  UMLC_FREE_MASK  = 8'h13;
  localparam int          UMLC_EFC_WEN   = 4;
  localparam int          UMLC_PIN_TR_BIT = 1;
  localparam int          UMLC_PIN_TR_ALT = 2;
  localparam int          UMLC_PIN_FIVE  = 5;
  localparam int          UMLC_PIN_ONE   = 1;
  localparam logic [1:0]  UMLC_DIV_LAST  = 2'h3;
  localparam int          UMLC_MSR_SEND  = 4;
  localparam int          UMLC_MSR_TERM  = 5;
  localparam int          UMLC_RSVD      = 3;
  localparam logic [1:0]  UMLC_DIV_RESET = 2'h0;
  localparam logic        UMLC_FLAG_RESET = 1'b0;
  localparam logic        UMLC_PIN_IDLE  = 1'b1;
endpackage : umlc_pkg

//--- dv/umlc_modem_model.sv
module umlc_modem_model
(
  // Pins seen by the far modem
  input  wire logic send_req_n_in,
  input  wire logic term_rdy_n_in,
  // Pins driven back by the far modem
  output logic      cts_n_out,
  output logic      dsr_n_out,
  output logic      rx_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Peer echoes handshakes back; its data line idles at mark
  assign cts_n_out  = send_req_n_in;
  assign dsr_n_out  = term_rdy_n_in;
  assign rx_pin_out = 1'b1;
endmodule : umlc_modem_model

//--- dv/umlc_modem_line_control_test.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module umlc_modem_line_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import umlc_pkg::*;
  logic       clk_in = 0, rstn_in = 0, ce_in = 1, wr_en_in = 0;
  logic       auto_rts_en_in = 0, auto_rts_n_in = 0, tx_serial_in = 0;
  logic [7:0] wr_data_in = 8'h00, efc_in = 8'h00;
  logic [7:0] pin_func_in = 8'h00, pin_state_in = 8'h00, rd_data_out;
  logic       rx_pin_in, cts_n_in, dsr_n_in, baud_clk_en_out, infrared_out;
  logic       any_resume_out, loopback_out, trig_regs_en_out, rx_serial_out;
  logic       status_cts_out, status_dsr_out, send_req_n_out;
  logic       pin_five_out, pin_one_out;
  logic [3:0] cnt;
  int         n_mismatch = 0, comparisons = 0, cycles = 0;
  // Design and far modem
  umlc_modem_line_control dut (.clk_in, .rstn_in, .ce_in, .wr_en_in,
    .wr_data_in, .efc_in, .pin_func_in, .pin_state_in, .rd_data_out,
    .auto_rts_en_in, .auto_rts_n_in, .tx_serial_in, .rx_pin_in, .cts_n_in,
    .dsr_n_in, .baud_clk_en_out, .infrared_out, .any_resume_out,
    .loopback_out, .trig_regs_en_out, .rx_serial_out, .status_cts_out,
    .status_dsr_out, .send_req_n_out, .pin_five_out, .pin_one_out);
  umlc_modem_model peer (.send_req_n_in(send_req_n_out),
    .term_rdy_n_in(pin_five_out), .cts_n_out(cts_n_in),
    .dsr_n_out(dsr_n_in), .rx_pin_out(rx_pin_in));
  // Clock and hang guard
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // One write pulse, then let derived outputs settle
  task automatic wr(input logic [7:0] d);
    @(negedge clk_in);
    wr_en_in   = 1'b1;
    wr_data_in = d;
    @(negedge clk_in);
    wr_en_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : wr
  // Counts baud enables over eight cycles
  task automatic baud();
    cnt = 4'h0;
    repeat (8) @(negedge clk_in) cnt += baud_clk_en_out;
  endtask : baud
  task automatic give_verdict();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clk_in);
    `CHK(rd_data_out, 8'h00)
    `CHK(send_req_n_out, 1'b1)
    rstn_in = 1'b1;
    wr(8'hFF);
    `CHK(rd_data_out, 8'h13)
    `CHK(loopback_out, 1'b1)
    `CHK(rx_serial_out, 1'b0)
    `CHK({status_cts_out, status_dsr_out}, 2'h3)
    `CHK(send_req_n_out, 1'b0)
    efc_in = 8'h10;
    wr(8'hFF);
    `CHK(rd_data_out, 8'hF7)
    `CHK({infrared_out, any_resume_out}, 2'h3)
    `CHK(trig_regs_en_out, 1'b1)
    baud();
    `CHK(cnt, 4'h2)
    pin_func_in  = 8'h06;
    pin_state_in = 8'hFF;
    wr(8'h01);
    `CHK({pin_five_out, pin_one_out}, 2'h0)
    `CHK(rx_serial_out, 1'b1)
    `CHK(status_cts_out, 1'b0)
    baud();
    `CHK(cnt, 4'h8)
    wr(8'h00);
    `CHK({pin_five_out, pin_one_out}, 2'h3)
    `CHK({any_resume_out, trig_regs_en_out}, 2'h0)
    auto_rts_en_in = 1'b1;
    auto_rts_n_in  = 1'b1;
    wr(8'h02);
    `CHK(send_req_n_out, 1'b1)
    // Pins back to general use follow their state bits
    auto_rts_en_in = 1'b0;
    pin_func_in    = 8'h00;
    pin_state_in   = 8'h00;
    wr(8'h02);
    `CHK({pin_five_out, pin_one_out}, 2'h0)
    `CHK(send_req_n_out, 1'b0)
    `CHK({status_cts_out, status_dsr_out}, 2'h3)
    // A low enable freezes every register
    ce_in = 1'b0;
    wr(8'h10);
    `CHK(rd_data_out, 8'h02)
    `CHK(loopback_out, 1'b0)
    ce_in = 1'b1;
    // Reset in mid-run, then the reserved bit is ignored
    rstn_in = 1'b0;
    @(negedge clk_in);
    `CHK(rd_data_out, 8'h00)
    `CHK({pin_five_out, send_req_n_out}, 2'h3)
    rstn_in = 1'b1;
    wr(8'h0C);
    `CHK(rd_data_out, 8'h04)
    `CHK(trig_regs_en_out, 1'b1)
    give_verdict();
  end
endmodule : umlc_modem_line_control_test
